// >>> rtl/ivnc_top.v
/*
 * Interrupt vector numbers and unmaskable-pin control, APB slave.
 * Assumes peripheral requests are level inputs synchronous to pclk, the CPU
 * pulses an accept with the chosen source, and the external vector byte is
 * valid on ext_vec_data while vec_fetch_req is high.
 */
`include "ivnc_defs.vh"

module ivnc_top (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Unmaskable pin
    input wire unmaskable_pin,
    output reg unmaskable_req,
    // Encoded external level request
    input wire [3:0] encoded_level_request,
    // CPU accept handshake
    input wire accept_valid,
    input wire [2:0] accept_source,
    input wire context_saved,
    output reg vec_fetch_req,
    input wire [7:0] ext_vec_data,
    output reg vec_valid,
    output reg [6:0] vec_number,
    output reg [31:0] vec_address,
    // Peripheral requests
    input wire rx_error_irq,
    input wire rx_full_irq,
    input wire tx_empty_irq,
    input wire tx_end_irq,
    input wire capture_irq,
    input wire compare_irq,
    input wire timer_overflow_irq,
    // Interrupt line
    output reg irq_out
);

    // ****************************************
    // APB decode
    // ****************************************
    wire wr_cycle = psel && penable && pwrite;
    wire wr_rxv = wr_cycle && (paddr == `IVNC_OFF_RXV);
    wire wr_txv = wr_cycle && (paddr == `IVNC_OFF_TXV);
    wire wr_ccv = wr_cycle && (paddr == `IVNC_OFF_CCV);
    wire wr_ovv = wr_cycle && (paddr == `IVNC_OFF_OVV);
    wire wr_ctl = wr_cycle && (paddr == `IVNC_OFF_ICTL);
    wire wr_base = wr_cycle && (paddr == `IVNC_OFF_BASE);
    wire wr_ien = wr_cycle && (paddr == `IVNC_OFF_IEN);
    wire wr_iclr = wr_cycle && (paddr == `IVNC_OFF_ICLR);

    // ****************************************
    // Vector registers
    // ****************************************
    wire [6:0] rx_error_vector;
    wire [6:0] rx_full_vector;
    wire [6:0] tx_empty_vector;
    wire [6:0] tx_end_vector;
    wire [6:0] capture_vector;
    wire [6:0] compare_vector;
    wire [6:0] overflow_vector;
    wire [15:0] rd_rxv;
    wire [15:0] rd_txv;
    wire [15:0] rd_ccv;
    wire [15:0] rd_ovv;

    ivnc_vec_pair #(.HAS_LOW(1)) u_rxv (
        .pclk(pclk), .presetn(presetn), .wr_en(wr_rxv), .wr_data(pwdata[15:0]),
        .hi_vec(rx_error_vector), .lo_vec(rx_full_vector), .rd_value(rd_rxv));
    ivnc_vec_pair #(.HAS_LOW(1)) u_txv (
        .pclk(pclk), .presetn(presetn), .wr_en(wr_txv), .wr_data(pwdata[15:0]),
        .hi_vec(tx_empty_vector), .lo_vec(tx_end_vector), .rd_value(rd_txv));
    ivnc_vec_pair #(.HAS_LOW(1)) u_ccv (
        .pclk(pclk), .presetn(presetn), .wr_en(wr_ccv), .wr_data(pwdata[15:0]),
        .hi_vec(capture_vector), .lo_vec(compare_vector), .rd_value(rd_ccv));
    ivnc_vec_pair #(.HAS_LOW(0)) u_ovv (
        .pclk(pclk), .presetn(presetn), .wr_en(wr_ovv), .wr_data(pwdata[15:0]),
        .hi_vec(overflow_vector), .lo_vec(), .rd_value(rd_ovv));

    // ****************************************
    // Control, base, pin level
    // ****************************************
    reg unmaskable_edge_select_q;
    reg external_vector_mode_q;
    reg unmaskable_pin_level_q;
    reg pin_prev_q;
    reg [31:0] vector_base_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unmaskable_edge_select_q <= 1'b0;
            external_vector_mode_q <= 1'b0;
            unmaskable_pin_level_q <= 1'b0;
            pin_prev_q <= 1'b0;
            vector_base_q <= 32'h00000000;
        end else begin
            // Level tracks pin every cycle, so after release bit 15 = pin
            unmaskable_pin_level_q <= unmaskable_pin;
            pin_prev_q <= unmaskable_pin_level_q;
            if (wr_ctl) begin
                unmaskable_edge_select_q <= pwdata[`IVNC_EDGE_SEL];
                external_vector_mode_q <= pwdata[`IVNC_EXT_MODE];
            end
            if (wr_base) begin
                vector_base_q <= pwdata;
            end
        end
    end

    wire pin_rise = unmaskable_pin_level_q && !pin_prev_q;
    wire pin_fall = !unmaskable_pin_level_q && pin_prev_q;
    wire [15:0] rd_ctl = {unmaskable_pin_level_q, 6'h00, unmaskable_edge_select_q,
                          7'h00, external_vector_mode_q};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unmaskable_req <= 1'b0;
        end else begin
            unmaskable_req <= unmaskable_edge_select_q ? pin_rise : pin_fall;
        end
    end

    // ****************************************
    // Event status, enable, clear
    // ****************************************
    wire [6:0] evt_in = {timer_overflow_irq, compare_irq, capture_irq, tx_end_irq,
                         tx_empty_irq, rx_full_irq, rx_error_irq};
    reg [6:0] evt_prev_q;
    reg [6:0] istat_q;
    reg [6:0] ien_q;
    wire [6:0] evt_rise = evt_in & ~evt_prev_q;
    wire [6:0] clr_mask = wr_iclr ? pwdata[6:0] : 7'h00;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_prev_q <= 7'h00;
            istat_q <= 7'h00;
            ien_q <= 7'h00;
            irq_out <= 1'b0;
        end else begin
            evt_prev_q <= evt_in;
            // Set wins over clear
            istat_q <= (istat_q & ~clr_mask) | evt_rise;
            if (wr_ien) begin
                ien_q <= pwdata[6:0];
            end
            irq_out <= |(((istat_q & ~clr_mask) | evt_rise) & ien_q);
        end
    end

    // ****************************************
    // Vector selection
    // ****************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_FETCH = 3'b100;

    reg [2:0] state_q;
    reg [6:0] sel_vec;
    reg [6:0] auto_vec;
    reg [6:0] last_vec_q;

    always @* begin
        case (accept_source)
            3'h0: sel_vec = rx_error_vector;
            3'h1: sel_vec = rx_full_vector;
            3'h2: sel_vec = tx_empty_vector;
            3'h3: sel_vec = tx_end_vector;
            3'h4: sel_vec = capture_vector;
            3'h5: sel_vec = compare_vector;
            3'h6: sel_vec = overflow_vector;
            default: sel_vec = 7'h00;
        endcase
    end

    always @* begin
        // Auto vector: level 15,14 -> 71; 1 -> 64; others 64 + level/2
        if (encoded_level_request == `IVNC_LVL_15 ||
            encoded_level_request == `IVNC_LVL_14) begin
            auto_vec = `IVNC_AUTO_HIGH;
        end else if (encoded_level_request == `IVNC_LVL_1) begin
            auto_vec = `IVNC_AUTO_LOW;
        end else begin
            auto_vec = `IVNC_AUTO_LOW + {4'h0, encoded_level_request[3:1]};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            vec_fetch_req <= 1'b0;
            vec_valid <= 1'b0;
            vec_number <= 7'h00;
            vec_address <= 32'h00000000;
            last_vec_q <= 7'h00;
        end else begin
            vec_valid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept_valid) begin
                        if (accept_source != `IVNC_SRC_EXT) begin
                            vec_valid <= 1'b1;
                            vec_number <= sel_vec;
                            vec_address <= vector_base_q + {23'h000000, sel_vec, 2'b00};
                            last_vec_q <= sel_vec;
                        end else if (!external_vector_mode_q) begin
                            vec_valid <= 1'b1;
                            vec_number <= auto_vec;
                            vec_address <= vector_base_q + {23'h000000, auto_vec, 2'b00};
                            last_vec_q <= auto_vec;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (context_saved) begin
                        vec_fetch_req <= 1'b1;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Byte sampled while fetch request is high
                    vec_fetch_req <= 1'b0;
                    vec_valid <= 1'b1;
                    vec_number <= ext_vec_data[6:0];
                    vec_address <= vector_base_q + {23'h000000, ext_vec_data[6:0], 2'b00};
                    last_vec_q <= ext_vec_data[6:0];
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    vec_fetch_req <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // APB read and answer
    // ****************************************
    reg [31:0] rd_mux;
    reg addr_ok;

    always @* begin
        addr_ok = 1'b1;
        case (paddr)
            `IVNC_OFF_RXV: rd_mux = {16'h0000, rd_rxv};
            `IVNC_OFF_TXV: rd_mux = {16'h0000, rd_txv};
            `IVNC_OFF_CCV: rd_mux = {16'h0000, rd_ccv};
            `IVNC_OFF_OVV: rd_mux = {16'h0000, rd_ovv};
            `IVNC_OFF_ICTL: rd_mux = {16'h0000, rd_ctl};
            `IVNC_OFF_BASE: rd_mux = vector_base_q;
            `IVNC_OFF_ISTAT: rd_mux = {25'h0000000, istat_q};
            `IVNC_OFF_IEN: rd_mux = {25'h0000000, ien_q};
            `IVNC_OFF_ICLR: rd_mux = 32'h00000000;
            `IVNC_OFF_ACCEPT: rd_mux = {25'h0000000, last_vec_q};
            default: begin
                rd_mux = 32'h00000000;
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

endmodule

// >>> shared/ivnc_defs.vh
/*
 * Register offsets, field positions, reset values and fixed vector numbers
 * for the interrupt vector and unmaskable-pin control block.
 * Assumes it is included by its bare name from rtl files.
 */
`ifndef IVNC_DEFS_VH
`define IVNC_DEFS_VH

// ****************************************
// Register byte offsets (APB)
// ****************************************
`define IVNC_OFF_RXV     12'h000
`define IVNC_OFF_TXV     12'h004
`define IVNC_OFF_CCV     12'h008
`define IVNC_OFF_OVV     12'h00c
`define IVNC_OFF_ICTL    12'h010
`define IVNC_OFF_BASE    12'h014
`define IVNC_OFF_ISTAT   12'h018
`define IVNC_OFF_IEN     12'h01c
`define IVNC_OFF_ICLR    12'h020
`define IVNC_OFF_ACCEPT  12'h024

// ****************************************
// Field positions
// ****************************************
`define IVNC_HI_MSB      14
`define IVNC_HI_LSB      8
`define IVNC_LO_MSB      6
`define IVNC_LO_LSB      0
`define IVNC_PIN_LEVEL   15
`define IVNC_EDGE_SEL    8
`define IVNC_EXT_MODE    0

// ****************************************
// Reset values and fixed vectors
// ****************************************
`define IVNC_VEC_RESET   16'h0000
`define IVNC_CTL_SET     16'h8000
`define IVNC_CTL_CLR     16'h0000
`define IVNC_AUTO_HIGH   7'h47
`define IVNC_AUTO_LOW    7'h40
`define IVNC_LVL_15      4'hf
`define IVNC_LVL_14      4'he
`define IVNC_LVL_1       4'h1

// ****************************************
// Source indices (0..6 peripheral, 7 external)
// ****************************************
`define IVNC_SRC_EXT     3'h7

`endif

// >>> rtl/ivnc_vec_pair.v
/*
 * One vector register holding two 7-bit vector numbers.
 * Assumes write strobe and data come from an APB slave in the parent.
 */
`include "ivnc_defs.vh"

module ivnc_vec_pair #(
    parameter HAS_LOW = 1
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write side
    input wire wr_en,
    input wire [15:0] wr_data,
    // Fields
    output wire [6:0] hi_vec,
    output wire [6:0] lo_vec,
    output wire [15:0] rd_value
);

    reg [6:0] hi_q;
    reg [6:0] lo_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 7'h00;
            lo_q <= 7'h00;
        end else if (wr_en) begin
            hi_q <= wr_data[`IVNC_HI_MSB:`IVNC_HI_LSB];
            if (HAS_LOW != 0) begin
                lo_q <= wr_data[`IVNC_LO_MSB:`IVNC_LO_LSB];
            end
        end
    end

    assign hi_vec = hi_q;
    assign lo_vec = (HAS_LOW != 0) ? lo_q : 7'h00;
    // Bits 15 and 7 read zero
    assign rd_value = {1'b0, hi_q, 1'b0, lo_vec};

endmodule

// >>> tb/ivnc_props_properties.sv
/* Port checks for the vector and unmaskable-pin control block.
   Assumes a bind to ivnc_top from the bench top file. */
module ivnc_props (
    // APB
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    // Unmaskable pin
    input logic unmaskable_pin,
    input logic unmaskable_req,
    // Vectoring
    input logic [3:0] encoded_level_request,
    input logic accept_valid,
    input logic [2:0] accept_source,
    input logic context_saved,
    input logic vec_fetch_req,
    input logic [7:0] ext_vec_data,
    input logic vec_valid,
    input logic [6:0] vec_number,
    input logic [31:0] vec_address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic edge_q, mode_q, wait_q;
    logic [31:0] base_q;
    wire done = psel && penable && pready;
    wire rd_ctl = done && !pwrite && paddr == 12'h010;
    wire ext_acc = accept_valid && accept_source == 3'h7;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // Shadow of control, base and pending fetch
    // ****
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 1'b0;
            mode_q <= 1'b0;
            wait_q <= 1'b0;
            base_q <= 32'h0;
        end else begin
            if (done && pwrite && paddr == 12'h010) begin
                edge_q <= pwdata[8];
                mode_q <= pwdata[0];
            end
            if (done && pwrite && paddr == 12'h014) begin
                base_q <= pwdata;
            end
            wait_q <= (wait_q || (ext_acc && mode_q)) && !vec_fetch_req;
        end
    end
    a_reserved_vec: assert property (
        done && !pwrite && paddr < 12'h010 |-> prdata[31:15] == 17'h0 && !prdata[7]
        && (paddr != 12'h00c || prdata[7:0] == 8'h0)) else $error("reserved vector bit set");
    a_reserved_ctl: assert property (
        rd_ctl |-> prdata[31:16] == 16'h0 && prdata[14:9] == 6'h0 && prdata[7:1] == 7'h0)
        else $error("reserved control bit set");
    a_pin_level: assert property (
        rd_ctl && $stable(unmaskable_pin) && $past(unmaskable_pin, 2) == unmaskable_pin
        |-> prdata[15] == unmaskable_pin) else $error("pin level bit wrong");
    a_edge_req: assert property (
        (!edge_q && $fell(unmaskable_pin)) || (edge_q && $rose(unmaskable_pin))
        |-> ##[1:2] unmaskable_req) else $error("no unmaskable request on edge");
    a_auto_vector: assert property (
        ext_acc && !mode_q && encoded_level_request != 4'h0 |=> vec_valid
        && vec_number == {4'h8, $past(encoded_level_request[3:1])}) else $error("auto vector");
    a_ext_wait: assert property (
        ext_acc && mode_q |=> !vec_valid [*2]) else $error("external mode gave early vector");
    a_fetch_save: assert property (
        wait_q && context_saved |=> vec_fetch_req) else $error("no fetch after save");
    a_ext_vector: assert property (
        vec_fetch_req |=> vec_valid && vec_number == $past(ext_vec_data[6:0]))
        else $error("external vector not taken");
    a_peri_vector: assert property (
        accept_valid && accept_source != 3'h7 |=> vec_valid) else $error("no peripheral vector");
    a_table_addr: assert property (
        vec_valid |-> vec_address == base_q + {23'h0, vec_number, 2'h0})
        else $error("table address wrong");
    c_ext_fetch: cover property (vec_fetch_req);
    c_edge_pulse: cover property (unmaskable_req);
    c_auto: cover property (ext_acc && !mode_q);
endmodule

// >>> tb/ivnc_cpu_model.sv
/* CPU side of the accept handshake and the external vector byte.
   Assumes the bench calls accept right after a rising clock edge. */
module ivnc_cpu_model (
    // Clock
    input logic pclk,
    // Accept side
    output logic accept_valid,
    output logic [2:0] accept_source,
    output logic context_saved,
    // External vector byte
    input logic vec_fetch_req,
    output logic [7:0] ext_vec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] byte_q = 8'h00;
    initial begin
        accept_valid = 1'b0;
        accept_source = 3'h0;
        context_saved = 1'b0;
    end
    // Byte only valid while fetched, inverted otherwise
    assign ext_vec_data = vec_fetch_req ? byte_q : ~byte_q;
    task automatic accept(input logic [2:0] src, input int dly, input logic [7:0] vb);
        byte_q <= vb;
        accept_valid <= 1'b1;
        accept_source <= src;
        @(posedge pclk);
        accept_valid <= 1'b0;
        if (dly > 0) begin
            repeat (dly) @(posedge pclk);
            context_saved <= 1'b1;
            @(posedge pclk);
            context_saved <= 1'b0;
        end
    endtask
endmodule

// >>> tb/tb.sv
/* Self-checking bench for ivnc_top with a CPU model.
   Assumes nothing beyond the design and the model. */
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic err;} ivnc_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err_q;
    logic unmaskable_pin = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd_q, prdata, vec_address;
    logic [3:0] encoded_level_request = 0;
    logic [6:0] ev = 0, vec_number;
    logic [7:0] ext_vec_data;
    logic [2:0] accept_source;
    logic pready, pslverr, unmaskable_req, vec_fetch_req, vec_valid, irq_out;
    logic accept_valid, context_saved;
    int n_fail = 0, check_count = 0, n_req = 0, cyc = 0, n0;
    ivnc_row_t rows[8] = '{
        '{12'h000, 32'h0000_2b15, 32'h0000_2b15, 1'b0},
        '{12'h004, 32'h0000_1234, 32'h0000_1234, 1'b0},
        '{12'h008, 32'h0000_7f7f, 32'h0000_7f7f, 1'b0},
        '{12'h00c, 32'h0000_4100, 32'h0000_4100, 1'b0},
        '{12'h010, 32'h0000_8100, 32'h0000_8100, 1'b0},
        '{12'h014, 32'h0000_1000, 32'h0000_1000, 1'b0},
        '{12'h020, 32'h0000_007f, 32'h0000_0000, 1'b0},
        '{12'h028, 32'h1234_5678, 32'h0000_0000, 1'b1}};
    logic [6:0] exp_vec[7] = '{7'h2b, 7'h15, 7'h12, 7'h34, 7'h7f, 7'h7f, 7'h41};
    logic [3:0] lv_tab[3] = '{4'hf, 4'he, 4'h1};
    logic [6:0] lv_exp[3] = '{7'd71, 7'd71, 7'd64};
    logic [7:0] ext_b[2] = '{8'h45, 8'h3a};
    ivnc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .unmaskable_pin, .unmaskable_req, .encoded_level_request,
        .accept_valid, .accept_source, .context_saved, .vec_fetch_req, .ext_vec_data,
        .vec_valid, .vec_number, .vec_address, .rx_error_irq(ev[0]), .rx_full_irq(ev[1]),
        .tx_empty_irq(ev[2]), .tx_end_irq(ev[3]), .capture_irq(ev[4]), .compare_irq(ev[5]),
        .timer_overflow_irq(ev[6]), .irq_out);
    ivnc_cpu_model i_cpu (.pclk, .accept_valid, .accept_source, .context_saved,
        .vec_fetch_req, .ext_vec_data);
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (unmaskable_req === 1'b1) n_req++;
        if (cyc == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_vec();
        do begin
            @(posedge pclk);
        end while (vec_valid !== 1'b1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(0, 12'(i * 4), 0);
            `CHK("reset value", (i == 4 ? 32'h8000 : 32'h0), rd_q)
        end
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].w);
            apb(0, rows[i].a, 0);
            `CHK("register read", rows[i].e, rd_q)
            `CHK("slave error", rows[i].err, err_q)
        end
        for (int s = 0; s < 7; s++) begin
            i_cpu.accept(3'(s), 0, 8'h00);
            wait_vec();
            `CHK("vector", exp_vec[s], vec_number)
            `CHK("table address", 32'h1000 + 4 * exp_vec[s], vec_address)
        end
        apb(1, 12'h010, 0);
        foreach (lv_tab[i]) begin
            encoded_level_request <= lv_tab[i];
            i_cpu.accept(3'h7, 0, 8'h00);
            wait_vec();
            `CHK("auto vector", lv_exp[i], vec_number)
        end
        apb(1, 12'h010, 32'h1);
        foreach (ext_b[i]) begin
            i_cpu.accept(3'h7, 1 + i * 4, ext_b[i]);
            wait_vec();
            `CHK("external vector", ext_b[i][6:0], vec_number)
            `CHK("external address", 32'h1000 + 4 * ext_b[i], vec_address)
        end
        apb(0, 12'h024, 0);
        `CHK("last vector", 32'h3a, rd_q)
        n0 = n_req;
        unmaskable_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK("falling pulses", n0 + 1, n_req)
        apb(1, 12'h010, 32'h0000_8101);
        apb(0, 12'h010, 0);
        `CHK("control pin low", 32'h0000_0101, rd_q)
        unmaskable_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1, 12'h010, 32'h1);
        unmaskable_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        unmaskable_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("edge pulses", n0 + 3, n_req)
        ev <= 7'h7f;
        @(posedge pclk);
        apb(0, 12'h018, 0);
        `CHK("status", 32'h7f, rd_q)
        `CHK("irq masked", 1'b0, irq_out)
        apb(1, 12'h01c, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq_out)
        apb(1, 12'h020, 32'h2);
        apb(0, 12'h018, 0);
        `CHK("status cleared", 32'h7d, rd_q)
        `CHK("irq cleared", 1'b0, irq_out)
        ev <= 7'h0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, 12'h000, 0);
        `CHK("vector after reset", 32'h0, rd_q)
        apb(0, 12'h010, 0);
        `CHK("control after reset", 32'h8000, rd_q)
        report_and_stop();
    end
endmodule
bind ivnc_top ivnc_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .unmaskable_pin, .unmaskable_req, .encoded_level_request,
    .accept_valid, .accept_source, .context_saved, .vec_fetch_req, .ext_vec_data,
    .vec_valid, .vec_number, .vec_address);
